// File: core/ocd_divider.sv
// Purpose: Two output channel dividers with bypass, force, sync, routing, power-down
// Assumes: Oscillator and external clock levels arrive synchronous to i_clk_sys
// Notes:   Divider steps on each rising edge of its selected source level
`timescale 1ns/1ps
// Operation
// RULE1 - Second divider stays low for low field plus one input cycles, default 3.
// RULE2 - Second divider stays high for high field plus one input cycles, default 3.
// RULE3 - Bypass bit 7 powers the divider down and passes its input through.
// RULE4 - Ignore bit 6 makes the divider disregard the chip-level sync pulse.
// RULE5 - Force bit 5 only acts while ignore-sync of that channel is set.
// RULE6 - Force zero drives output low; force one drives the start-high level.
// RULE7 - Force has no effect when bypassed; polarity reversal still works.
// RULE8 - Start-high bit 4 picks the divider's starting level, default low.
// RULE9 - Each divider has a four-bit phase offset in bits 3:0, reset zero.
// RULE10 - Power-down bit 2 puts all three outputs of the channel safely down.
// RULE11 - Direct bit 1 at zero drives the three outputs from the divider.
// RULE12 - Direct set with clock select 10b routes the oscillator to outputs.
// RULE13 - Direct set with clock select 00b routes the external clock to outputs.
// RULE14 - Clock select 01b leaves the direct bit without routing effect.
// RULE15 - Bit 0 set disables duty-cycle correction; zero keeps it enabled.
// RULE16 - First divider low and high counts both default to 7.
// RULE17 - Output period equals low duration plus high duration, each field plus one.
// RULE18 - Sync restarts non-ignoring dividers at start level and phase offset.
module ocd_divider
   import ocd_pkg::*;
(
   // Clock and reset
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_rst_b,
   // Register port
   input  wire ocd_pkg::ocd_wr_t     i_wr,
   input  wire logic [9:0]           i_rd_addr,
   output logic [7:0]                o_rd_data,
   // Clock sources and chip-level controls
   input  wire logic                 i_osc_clk,
   input  wire logic                 i_ext_clk,
   input  wire logic [1:0]           i_front_end_clock_select,
   input  wire logic                 i_sync,
   input  wire logic [1:0]           i_pol_inv,
   // Channel outputs
   output ocd_pkg::ocd_outs_t [1:0]  o_chan_out,
   output logic [1:0]                o_chan_pd,
   output logic [1:0]                o_duty_fix_en
);
   import ocd_pkg::*;

   ocd_state_t s_q;
   ocd_state_t s_d;

   logic [1:0][3:0] lo_v;
   logic [1:0][3:0] hi_v;
   logic [1:0][3:0] ph_v;
   logic [1:0]      byp_v;
   logic [1:0]      ign_v;
   logic [1:0]      frc_v;
   logic [1:0]      sth_v;
   logic [1:0]      pd_v;
   logic [1:0]      dir_v;
   logic [1:0]      dcc_off_v;
   logic [1:0]      run_v;
   logic            src;
   logic            tick;

   function automatic logic [2:0] reg_index(input logic [9:0] addr);
      if (addr >= ADDR_BASE && addr <= ADDR_LAST) begin
         reg_index = 3'(addr - ADDR_BASE);
      end else begin
         reg_index = IDX_NONE;
      end
   endfunction

   // The route is decided once per channel so the output mux stays flat
   function automatic ocd_route_t route_of(input logic byp, input logic dir,
                                           input logic [1:0] fes);
      if (dir && fes == FES_OSC) begin
         route_of = OCD_RT_OSC;
      end else if (dir && fes == FES_EXT) begin
         route_of = OCD_RT_EXT;
      end else if (byp) begin
         route_of = OCD_RT_BYP;
      end else begin
         route_of = OCD_RT_DIV;
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_cfg
         assign lo_v[g]      = s_q.regs[g*3+SLOT_CNT][LO_MSB:LO_LSB]; // [RULE1]
         assign hi_v[g]      = s_q.regs[g*3+SLOT_CNT][HI_MSB:HI_LSB]; // [RULE2]
         assign ph_v[g]      = s_q.regs[g*3+SLOT_CTL][PH_MSB:PH_LSB]; // [RULE9]
         assign byp_v[g]     = s_q.regs[g*3+SLOT_CTL][CTL_BYP];
         assign ign_v[g]     = s_q.regs[g*3+SLOT_CTL][CTL_IGN];
         assign frc_v[g]     = s_q.regs[g*3+SLOT_CTL][CTL_FRC];
         assign sth_v[g]     = s_q.regs[g*3+SLOT_CTL][CTL_STH];
         assign pd_v[g]      = s_q.regs[g*3+SLOT_RTE][RTE_PD];
         assign dir_v[g]     = s_q.regs[g*3+SLOT_RTE][RTE_DIR];
         assign dcc_off_v[g] = s_q.regs[g*3+SLOT_RTE][RTE_DCC];
         // Divider counts only when it is neither bypassed nor powered down
         assign run_v[g]     = !byp_v[g] && !pd_v[g]; // [RULE3]
      end
   endgenerate

   // Divider input: external clock for select 00b, oscillator otherwise
   assign src  = (i_front_end_clock_select == FES_EXT) ? i_ext_clk : i_osc_clk;
   assign tick = src && !((i_front_end_clock_select == FES_EXT) ? s_q.ext : s_q.osc);

   always_comb begin
      logic       lvl;
      logic       raw;
      logic [2:0] idx;
      ocd_route_t rt;
      lvl = 1'b0;
      raw = 1'b0;
      idx = IDX_NONE;
      rt  = OCD_RT_DIV;
      s_d = s_q;
      s_d.osc = i_osc_clk;
      s_d.ext = i_ext_clk;
      idx = reg_index(i_wr.addr);
      if (i_wr.we && idx != IDX_NONE) begin
         // Unused route bits are kept at zero so they read back as zero
         if (idx == 3'(SLOT_RTE) || idx == 3'(3 + SLOT_RTE)) begin
            s_d.regs[idx] = i_wr.wdata & RTE_MASK;
         end else begin
            s_d.regs[idx] = i_wr.wdata;
         end
      end
      idx = reg_index(i_rd_addr);
      s_d.rdata = (idx == IDX_NONE) ? 8'h00 : s_q.regs[idx];
      for (int c = 0; c < NCH; c++) begin
         if (i_sync && !ign_v[c]) begin // [RULE4]
            // Restart at start level, first span stretched by the phase offset
            s_d.ch[c].lvl = sth_v[c]; // [RULE8] [RULE18]
            s_d.ch[c].cnt = (sth_v[c] ? {1'b0, hi_v[c]} : {1'b0, lo_v[c]})
                            + {1'b0, ph_v[c]}; // [RULE9] [RULE18]
         end else if (tick && run_v[c]) begin
            if (s_q.ch[c].cnt == 5'h00) begin
               // Each half lasts field plus one ticks, so period is their sum
               s_d.ch[c].lvl = !s_q.ch[c].lvl; // [RULE17]
               s_d.ch[c].cnt = s_q.ch[c].lvl ? {1'b0, lo_v[c]}
                                             : {1'b0, hi_v[c]}; // [RULE1] [RULE2]
            end else begin
               s_d.ch[c].cnt = s_q.ch[c].cnt - 5'h01;
            end
         end
         // Ignoring sync forces the divider output; bypass skips the force
         if (ign_v[c]) begin // [RULE5]
            lvl = frc_v[c] & sth_v[c]; // [RULE6]
         end else begin
            lvl = s_q.ch[c].lvl;
         end
         rt = route_of(byp_v[c], dir_v[c], i_front_end_clock_select); // [RULE14]
         case (rt)
            OCD_RT_DIV: raw = lvl; // [RULE11]
            OCD_RT_BYP: raw = src; // [RULE3] [RULE7]
            OCD_RT_OSC: raw = i_osc_clk; // [RULE12]
            OCD_RT_EXT: raw = i_ext_clk; // [RULE13]
            default:    raw = 1'b0;
         endcase
         raw = raw ^ i_pol_inv[c]; // [RULE7]
         // Safe power-down parks all three clock outputs of the channel low
         if (pd_v[c]) begin // [RULE10]
            raw = 1'b0;
         end
         s_d.ch[c].outs   = {raw, raw, raw};
         s_d.ch[c].pd     = pd_v[c]; // [RULE10]
         s_d.ch[c].dcc_en = !dcc_off_v[c]; // [RULE15]
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s_q         <= '0;
         s_q.regs[0] <= RST_CNT_CH0; // [RULE16]
         s_q.regs[1] <= RST_CTL; // [RULE9]
         s_q.regs[2] <= RST_RTE;
         s_q.regs[3] <= RST_CNT_CH1; // [RULE1] [RULE2]
         s_q.regs[4] <= RST_CTL;
         s_q.regs[5] <= RST_RTE;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rd_data = s_q.rdata;
   generate
      for (g = 0; g < NCH; g++) begin : g_out
         assign o_chan_out[g]    = s_q.ch[g].outs;
         assign o_chan_pd[g]     = s_q.ch[g].pd;
         assign o_duty_fix_en[g] = s_q.ch[g].dcc_en;
      end
   endgenerate

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);

   logic quiet1;
   assign quiet1 = !i_sync && !i_wr.we;

   property p_low_span;
      tick && quiet1 && run_v[1] && !ign_v[1] && s_q.ch[1].cnt == 5'h00 && s_q.ch[1].lvl
      |=> !s_q.ch[1].lvl && s_q.ch[1].cnt == {1'b0, lo_v[1]};
   endproperty
   a_low_span: assert property (p_low_span) else $error("low span reload wrong"); // [RULE1]

   property p_high_span;
      tick && quiet1 && run_v[1] && !ign_v[1] && s_q.ch[1].cnt == 5'h00 && !s_q.ch[1].lvl
      |=> s_q.ch[1].lvl && s_q.ch[1].cnt == {1'b0, hi_v[1]};
   endproperty
   a_high_span: assert property (p_high_span) else $error("high span reload wrong"); // [RULE2]

   property p_bypass;
      quiet1 && byp_v[1] && !pd_v[1] && !dir_v[1]
      |=> o_chan_out[1].a == ($past(src) ^ $past(i_pol_inv[1])) && $stable(s_q.ch[1].cnt);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass path wrong"); // [RULE3]

   property p_ignore;
      i_sync && ign_v[1] && !(tick && run_v[1]) |=> $stable(s_q.ch[1].cnt);
   endproperty
   a_ignore: assert property (p_ignore) else $error("sync not ignored"); // [RULE4]

   property p_force;
      quiet1 && ign_v[1] && !byp_v[1] && !pd_v[1] && !dir_v[1]
      |=> o_chan_out[1].b == (($past(frc_v[1]) & $past(sth_v[1])) ^ $past(i_pol_inv[1]));
   endproperty
   a_force: assert property (p_force) else $error("forced level wrong"); // [RULE6]

   property p_sync_restart;
      i_sync && !ign_v[0] && !i_wr.we
      |=> s_q.ch[0].lvl == $past(sth_v[0])
          && s_q.ch[0].cnt == ($past(sth_v[0]) ? {1'b0, $past(hi_v[0])}
                                               : {1'b0, $past(lo_v[0])}) + {1'b0, $past(ph_v[0])};
   endproperty
   a_sync_restart: assert property (p_sync_restart) else $error("sync restart wrong"); // [RULE18]

   property p_power_down;
      pd_v[0] && !i_wr.we |=> o_chan_out[0] == '0 && o_chan_pd[0];
   endproperty
   a_power_down: assert property (p_power_down) else $error("power-down outputs active"); // [RULE10]

   property p_osc_direct;
      quiet1 && dir_v[1] && !pd_v[1] && i_front_end_clock_select == FES_OSC
      |=> o_chan_out[1].c == ($past(i_osc_clk) ^ $past(i_pol_inv[1]));
   endproperty
   a_osc_direct: assert property (p_osc_direct) else $error("oscillator route wrong"); // [RULE12]

   property p_ext_direct;
      quiet1 && dir_v[0] && !pd_v[0] && i_front_end_clock_select == FES_EXT
      |=> o_chan_out[0].a == ($past(i_ext_clk) ^ $past(i_pol_inv[0]));
   endproperty
   a_ext_direct: assert property (p_ext_direct) else $error("external route wrong"); // [RULE13]

   property p_no_direct;
      quiet1 && dir_v[1] && !byp_v[1] && !ign_v[1] && !pd_v[1]
      && i_front_end_clock_select == FES_NONE
      |=> o_chan_out[1].a == ($past(s_q.ch[1].lvl) ^ $past(i_pol_inv[1]));
   endproperty
   a_no_direct: assert property (p_no_direct) else $error("select 01b rerouted"); // [RULE14]

   property p_dcc;
      !i_wr.we |=> o_duty_fix_en[1] == !$past(dcc_off_v[1]);
   endproperty
   a_dcc: assert property (p_dcc) else $error("duty fix enable wrong"); // [RULE15]

   property p_force_idle;
      quiet1 && frc_v[1] && !ign_v[1] && !byp_v[1] && !pd_v[1] && !dir_v[1]
      |=> o_chan_out[1].a == ($past(s_q.ch[1].lvl) ^ $past(i_pol_inv[1]));
   endproperty
   a_force_idle: assert property (p_force_idle) else $error("force without ignore"); // [RULE5]

   property p_bypass_force;
      quiet1 && byp_v[1] && ign_v[1] && frc_v[1] && !pd_v[1] && !dir_v[1]
      |=> o_chan_out[1].c == ($past(src) ^ $past(i_pol_inv[1]));
   endproperty
   a_bypass_force: assert property (p_bypass_force) else $error("force beat bypass"); // [RULE7]

   property p_div_route;
      quiet1 && !dir_v[0] && !byp_v[0] && !ign_v[0] && !pd_v[0]
      |=> o_chan_out[0].c == ($past(s_q.ch[0].lvl) ^ $past(i_pol_inv[0]));
   endproperty
   a_div_route: assert property (p_div_route) else $error("divider route wrong"); // [RULE11]

   property p_count_step;
      tick && quiet1 && run_v[0] && s_q.ch[0].cnt != 5'h00
      |=> s_q.ch[0].cnt == $past(s_q.ch[0].cnt) - 5'h01
          && $stable(s_q.ch[0].lvl);
   endproperty
   a_count_step: assert property (p_count_step) else $error("count step wrong"); // [RULE17]

   property p_frozen;
      !run_v[1] && !i_sync |=> $stable(s_q.ch[1].cnt) && $stable(s_q.ch[1].lvl);
   endproperty
   a_frozen: assert property (p_frozen) else $error("stopped divider counted"); // [RULE3] [RULE10]

   property p_read_route;
      i_rd_addr == ADDR_CH0_RTE
      |=> o_rd_data == {5'h00, $past(pd_v[0]), $past(dir_v[0]), $past(dcc_off_v[0])};
   endproperty
   a_read_route: assert property (p_read_route) else $error("route readback wrong"); // [RULE10]

   c_toggle:   cover property (tick && run_v[1] && s_q.ch[1].cnt == 5'h00);
   c_sync:     cover property (i_sync && !ign_v[0] && ph_v[0] != 4'h0);
   c_bypass:   cover property (byp_v[1] && !pd_v[1] ##1 o_chan_out[1].a);
   c_powerdn:  cover property (pd_v[0] ##1 o_chan_pd[0]);
   c_direct:   cover property (dir_v[0] && i_front_end_clock_select == FES_EXT);
endmodule // ocd_divider

// File: core/ocd_pkg.sv
// Purpose: Constants and types for the output channel divider block
// Assumes: Register offsets are the printed byte addresses of the control port
// Notes:   Two channels; each owns counts, control and route/power registers
package ocd_pkg;
   localparam int          NCH          = 2;
   localparam int          NREG         = 6;
   localparam logic [9:0]  ADDR_BASE    = 10'h190;
   localparam logic [9:0]  ADDR_CH0_RTE = 10'h192;
   localparam logic [9:0]  ADDR_CH1_CNT = 10'h193;
   localparam logic [9:0]  ADDR_CH1_CTL = 10'h194;
   localparam logic [9:0]  ADDR_LAST    = 10'h195;
   localparam logic [2:0]  IDX_NONE     = 3'h7;
   // Register slots inside one channel
   localparam int          SLOT_CNT     = 0;
   localparam int          SLOT_CTL     = 1;
   localparam int          SLOT_RTE     = 2;
   localparam logic [7:0]  RST_CNT_CH0  = 8'h77;
   localparam logic [7:0]  RST_CNT_CH1  = 8'h33;
   localparam logic [7:0]  RST_CTL      = 8'h00;
   localparam logic [7:0]  RST_RTE      = 8'h00;
   localparam logic [7:0]  RTE_MASK     = 8'h07;
   // Field positions
   localparam int          LO_MSB       = 7;
   localparam int          LO_LSB       = 4;
   localparam int          HI_MSB       = 3;
   localparam int          HI_LSB       = 0;
   localparam int          PH_MSB       = 3;
   localparam int          PH_LSB       = 0;
   localparam int          CTL_BYP      = 7;
   localparam int          CTL_IGN      = 6;
   localparam int          CTL_FRC      = 5;
   localparam int          CTL_STH      = 4;
   localparam int          RTE_PD       = 2;
   localparam int          RTE_DIR      = 1;
   localparam int          RTE_DCC      = 0;
   localparam logic [1:0]  FES_EXT      = 2'b00;
   localparam logic [1:0]  FES_NONE     = 2'b01;
   localparam logic [1:0]  FES_OSC      = 2'b10;

   typedef enum logic [1:0] {
      OCD_RT_DIV = 2'b00,
      OCD_RT_BYP = 2'b01,
      OCD_RT_OSC = 2'b10,
      OCD_RT_EXT = 2'b11
   } ocd_route_t;

   typedef struct packed {
      logic       we;
      logic [9:0] addr;
      logic [7:0] wdata;
   } ocd_wr_t;

   typedef struct packed {
      logic a;
      logic b;
      logic c;
   } ocd_outs_t;

   typedef struct packed {
      logic [4:0] cnt;
      logic       lvl;
      ocd_outs_t  outs;
      logic       pd;
      logic       dcc_en;
   } ocd_ch_t;

   typedef struct packed {
      logic [NREG-1:0][7:0] regs;
      ocd_ch_t [NCH-1:0]    ch;
      logic                 osc;
      logic                 ext;
      logic [7:0]           rdata;
   } ocd_state_t;
endpackage

// File: tb/ocd_clock_partner.sv
// Purpose: Clock sources that feed the channel dividers
// Assumes: Sources are levels stepped on the system clock
// Notes:   Oscillator toggles every cycle, external clock every EXT_HALF cycles
`timescale 1ns/1ps
module ocd_clock_partner #(
   parameter int EXT_HALF = 3
) (
   // Clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_rst_b,
   // Source levels
   output logic      o_osc_clk,
   output logic      o_ext_clk
);
   int ext_cnt;

   // Sources move on the falling edge so the block samples settled levels
   always @(negedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_osc_clk <= 1'b0;
         o_ext_clk <= 1'b0;
         ext_cnt   <= 0;
      end
      else begin
         o_osc_clk <= ~o_osc_clk;
         if (ext_cnt == EXT_HALF - 1) begin
            ext_cnt   <= 0;
            o_ext_clk <= ~o_ext_clk;
         end
         else begin
            ext_cnt <= ext_cnt + 1;
         end
      end
   end
endmodule // ocd_clock_partner

// File: tb/output_channel_divider_tb_top.sv
// Purpose: Self-checking bench for the output channel dividers
// Assumes: Inputs change on the falling edge; sources come from the partner
// Notes:   Run lengths are counted in system clock cycles
`timescale 1ns/1ps
module output_channel_divider_tb_top;
   import ocd_pkg::*;
   logic            clk_sys;
   logic            rst_b;
   ocd_wr_t         wr;
   logic [9:0]      rd_addr;
   logic [7:0]      rd_data;
   logic            osc;
   logic            ext;
   logic [1:0]      fes;
   logic            sync;
   logic [1:0]      pol_inv;
   ocd_outs_t [1:0] chan_out;
   logic [1:0]      chan_pd;
   logic [1:0]      dfix;
   int              errors = 0;
   int              total_checks = 0;
   int              h0;
   int              h15;

   ocd_divider i_ocd_divider (
      .i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_wr(wr), .i_rd_addr(rd_addr),
      .o_rd_data(rd_data), .i_osc_clk(osc), .i_ext_clk(ext),
      .i_front_end_clock_select(fes), .i_sync(sync), .i_pol_inv(pol_inv),
      .o_chan_out(chan_out), .o_chan_pd(chan_pd), .o_duty_fix_en(dfix));

   ocd_clock_partner i_ocd_clock_partner (
      .i_clk_sys(clk_sys), .i_rst_b(rst_b), .o_osc_clk(osc), .o_ext_clk(ext));

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end
      else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Settles a few cycles so the new setting has reached the outputs
   task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      wr <= '{we: 1'b1, addr: a, wdata: d};
      @(negedge clk_sys);
      wr.we <= 1'b0;
      repeat (3) @(negedge clk_sys);
   endtask

   task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      rd_addr <= a;
      @(negedge clk_sys);
      chk("read data", exp, rd_data);
   endtask

   // Two rising edges of the output are awaited so a route or count change cannot leave a partial run
   task automatic chk_runs(input int c, input int ehi, input int elo);
      int hi;
      int lo;
      int k;
      hi = 0;
      lo = 0;
      k = 0;
      for (int p = 0; p < 2; p++) begin
         while (chan_out[c].a !== 1'b0 && k < 250) begin
            @(negedge clk_sys);
            k++;
         end
         while (chan_out[c].a !== 1'b1 && k < 250) begin
            @(negedge clk_sys);
            k++;
         end
      end
      while (chan_out[c].a === 1'b1 && hi < 250) begin
         @(negedge clk_sys);
         hi++;
      end
      while (chan_out[c].a === 1'b0 && lo < 250) begin
         @(negedge clk_sys);
         lo++;
      end
      chk("high run", 8'(ehi), 8'(hi));
      chk("low run", 8'(elo), 8'(lo));
   endtask

   task automatic sync_run(input logic [7:0] ctl, output int hi);
      wr_reg(ADDR_CH1_CTL, ctl);
      if (osc !== 1'b0) begin
         @(negedge clk_sys);
      end
      sync <= 1'b1;
      @(negedge clk_sys);
      sync <= 1'b0;
      repeat (2) @(negedge clk_sys);
      chk("start level", 8'h01, {7'h00, chan_out[1].a});
      hi = 0;
      while (chan_out[1].a === 1'b1 && hi < 250) begin
         @(negedge clk_sys);
         hi++;
      end
   endtask

   task automatic t_regs();
      logic [7:0] exp [7] = '{8'h77, 8'h00, 8'h00, 8'h33, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 7; i++) begin
         rd_chk(ADDR_BASE + 10'(i), exp[i]);
      end
      chk("duty fix enable", 8'h03, {6'h00, dfix});
      chk("power down", 8'h00, {6'h00, chan_pd});
      wr_reg(ADDR_LAST, 8'hFF);
      rd_chk(ADDR_LAST, 8'h07);
      wr_reg(ADDR_CH0_RTE, 8'hFF);
      rd_chk(ADDR_CH0_RTE, 8'h07);
      chk("power down", 8'h03, {6'h00, chan_pd});
      chk("duty fix enable", 8'h00, {6'h00, dfix});
      wr_reg(10'h196, 8'h55);
      rd_chk(10'h196, 8'h00);
      wr_reg(ADDR_LAST, 8'h00);
      wr_reg(ADDR_CH0_RTE, 8'h00);
   endtask

   task automatic t_force();
      logic [7:0] ctl [5] = '{8'h40, 8'h60, 8'h70, 8'h50, 8'h40};
      logic [1:0] pol [5] = '{2'b00, 2'b00, 2'b00, 2'b00, 2'b10};
      logic [2:0] exp [5] = '{3'b000, 3'b000, 3'b111, 3'b000, 3'b111};
      for (int i = 0; i < 5; i++) begin
         pol_inv <= pol[i];
         wr_reg(ADDR_CH1_CTL, ctl[i]);
         chk("forced level", {5'h00, exp[i]}, {5'h00, chan_out[1]});
      end
      pol_inv <= 2'b00;
      wr_reg(ADDR_CH1_CTL, 8'h30);
      chk_runs(1, 8, 8);
      wr_reg(ADDR_CH1_CTL, 8'h80);
      chk_runs(1, 1, 1);
      wr_reg(ADDR_CH1_CTL, 8'hE0);
      chk_runs(1, 1, 1);
      wr_reg(ADDR_CH1_CTL, 8'h00);
   endtask

   task automatic t_route();
      wr_reg(ADDR_LAST, 8'h02);
      wr_reg(ADDR_CH0_RTE, 8'h02);
      chk_runs(1, 1, 1);
      chk_runs(0, 1, 1);
      fes <= FES_EXT;
      chk_runs(1, 3, 3);
      chk_runs(0, 3, 3);
      fes <= FES_NONE;
      chk_runs(1, 8, 8);
      chk_runs(0, 16, 16);
      fes <= FES_OSC;
      wr_reg(ADDR_CH0_RTE, 8'h00);
      pol_inv <= 2'b10;
      wr_reg(ADDR_LAST, 8'h04);
      chk("power down", 8'h02, {6'h00, chan_pd});
      chk("powered outputs", 8'h00, {5'h00, chan_out[1]});
      pol_inv <= 2'b00;
      wr_reg(ADDR_LAST, 8'h01);
      chk("duty fix enable", 8'h01, {6'h00, dfix});
      wr_reg(ADDR_LAST, 8'h00);
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   initial begin
      #200000;
      errors++;
      end_sim();
   end

   initial begin
      rst_b = 1'b0;
      wr = '0;
      rd_addr = ADDR_BASE;
      fes = FES_OSC;
      sync = 1'b0;
      pol_inv = 2'b00;
      repeat (20) @(negedge clk_sys);
      rst_b <= 1'b1;
      t_regs();
      chk_runs(0, 16, 16);
      chk_runs(1, 8, 8);
      wr_reg(ADDR_CH1_CNT, 8'h12);
      rd_chk(ADDR_CH1_CNT, 8'h12);
      chk_runs(1, 6, 4);
      wr_reg(ADDR_CH1_CNT, 8'h33);
      t_force();
      t_route();
      sync_run(8'h10, h0);
      sync_run(8'h1F, h15);
      chk("offset span", 8'h1E, 8'(h15 - h0));
      end_sim();
   end
endmodule // output_channel_divider_tb_top
